// >>> hw/mrs_pkg.sv
/*
  Constants, types and helpers of the motor ramp and stop controller.
  Assumes a 100 MHz control clock and an APB register bus of 32-bit words.
*/
// Behaviour
// - stop ramps down (00) or coasts (01)
// - restart after coast from 0 Hz or match
// - matched frequency below threshold restarts from zero
// - wait retry time after coast before restart
// - stop-key permission gates stop and trip reset
// - permission ignored when keypad is run source
// - accel time sets slope zero to maximum
// - decel time sets slope maximum to zero
// - ramp bypass makes output follow command immediately
// - two terminals pick one of three sets
// - ramp-time source picks keypad, boards or program
// - base frequency from 30 Hz to maximum
// - regulation holds output at selected motor voltage
// - regulation on, off, or off while decelerating
// - run source 02 means keypad commands
package mrs_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int WAIT_UNIT_NS = 100_000_000;
  localparam int WAIT_TICKS = WAIT_UNIT_NS / TICK_NS;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_THR = 8'h04;
  localparam logic [7:0] OFF_WAIT = 8'h08;
  localparam logic [7:0] OFF_FMAX = 8'h0C;
  localparam logic [7:0] OFF_ACC0 = 8'h10;
  localparam logic [7:0] OFF_DEC0 = 8'h1C;
  localparam logic [7:0] OFF_BASE0 = 8'h28;
  localparam logic [7:0] OFF_STAT = 8'h34;
  localparam logic [7:0] OFF_FOUT = 8'h38;
  localparam logic [7:0] OFF_VOUT = 8'h3C;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int F_SMS = 0;
  localparam int F_RAC = 2;
  localparam int F_SKP = 4;
  localparam int F_RCS = 6;
  localparam int F_RTS = 9;
  localparam int F_VRM = 11;
  localparam int F_MVL = 13;
  localparam logic [1:0] STOP_COAST = 2'h1;
  localparam logic [1:0] RESTART_MATCH = 2'h1;
  localparam logic [1:0] KEY_ALL = 2'h0;
  localparam logic [1:0] KEY_NONE = 2'h1;
  localparam logic [1:0] KEY_RESET = 2'h2;
  localparam logic [2:0] SRC_KEYPAD = 3'h2;
  localparam logic [2:0] SRC_LAST = 3'h5;
  localparam logic [1:0] RTS_KEYPAD = 2'h0;
  localparam logic [1:0] VR_ON = 2'h0;
  localparam logic [1:0] VR_NODEC = 2'h2;
  localparam logic [2:0] MVL_LAST = 3'h5;
  // ----------------------------------------------------------------
  // Limits (frequency 0.01 Hz, ramp time 0.01 s, wait 0.1 s) and resets
  // ----------------------------------------------------------------
  localparam logic [15:0] THR_MAX = 16'h9C40;
  localparam logic [9:0] WAIT_MIN = 10'h003;
  localparam logic [9:0] WAIT_MAX = 10'h3E8;
  localparam logic [19:0] TIME_MIN = 20'h00001;
  localparam logic [19:0] TIME_MAX = 20'h57E40;
  localparam logic [15:0] FREQ_MIN = 16'h0BB8;
  localparam logic [15:0] FREQ_MAX = 16'h9C40;
  localparam logic [15:0] RST_CTRL = 16'h0040;
  localparam logic [9:0] RST_WAIT = 10'h00A;
  localparam logic [15:0] RST_FREQ = 16'h1770;
  localparam logic [19:0] RST_TIME = 20'h00BB8;

  typedef enum logic [2:0] {ST_STOP, ST_RUN, ST_DECEL, ST_COAST, ST_WAIT} mrs_state_e;

  // Motor voltage levels in volts; unused codes fall back to the lowest.
  function automatic logic [9:0] mrs_volt(input logic [2:0] i);
    case (i)
      3'h1: mrs_volt = 10'h190;
      3'h2: mrs_volt = 10'h19F;
      3'h3: mrs_volt = 10'h1B8;
      3'h4: mrs_volt = 10'h1CC;
      3'h5: mrs_volt = 10'h1E0;
      default: mrs_volt = 10'h17C;
    endcase
  endfunction
endpackage

// >>> hw/mrs_div_if.sv
/*
  Handshake between the controller and its ramp-step divider.
  Assumes both ends share one clock; start is a one-cycle pulse.
*/
interface mrs_div_if #(parameter int DW = 24, parameter int VW = 20);
  logic start;
  logic [DW-1:0] dividend;
  logic [VW-1:0] divisor;
  logic busy;
  logic done;
  logic [DW-1:0] quotient;
  modport master(output start, dividend, divisor, input busy, done, quotient);
  modport slave(input start, dividend, divisor, output busy, done, quotient);
endinterface

// >>> hw/mrs_div.sv
/*
  Sequential restoring divider producing the per-tick ramp step.
  Assumes start comes only while not busy and the divisor is never zero.
*/
module mrs_div #(
  parameter int DW = 24,
  parameter int VW = 20
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Request and answer.
  mrs_div_if.slave div
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [VW-1:0] dvs;
    logic [VW-1:0] rem;
    logic [DW-1:0] quo;
    logic [DW-1:0] res;
  } mrs_div_s;

  mrs_div_s r;
  mrs_div_s next_r;

  if (DW > 63 || VW > DW || DW < 2) begin : g_bad
    $error("mrs_div: unsupported widths");
  end

  // One quotient bit per cycle; a slow divider is cheap and steps change rarely.
  always_comb begin
    logic [VW:0] rs;
    rs = '0;
    next_r = r;
    next_r.done = 1'b0;
    if (!r.busy) begin
      if (div.start) begin
        next_r.busy = 1'b1;
        next_r.cnt = 6'(DW);
        next_r.dvs = div.divisor;
        next_r.rem = '0;
        next_r.quo = div.dividend;
      end
    end else begin
      rs = {r.rem, r.quo[DW-1]};
      next_r.quo = {r.quo[DW-2:0], 1'b0};
      if (rs >= {1'b0, r.dvs}) begin
        rs = rs - {1'b0, r.dvs};
        next_r.quo[0] = 1'b1;
      end
      next_r.rem = rs[VW-1:0];
      next_r.cnt = r.cnt - 6'd1;
      if (r.cnt == 6'd1) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        next_r.res = next_r.quo;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign div.busy = r.busy;
  assign div.done = r.done;
  assign div.quotient = r.res;

  // Latency of the default 24-bit divider is fixed.
  a_div_latency: assert property (@(posedge clk_in) disable iff (srst_in)
    (div.start && !r.busy) |-> ##25 r.done)
    else $error("divider answer late or early");
endmodule

// >>> hw/mrs_ctrl.sv
/*
  Run/stop sequencing, ramp generator and voltage reference of a motor drive.
  Assumes synchronous inputs, an APB master and 0.01 Hz frequency units.
*/
// The placing of the registers and the APB interface to the registers are this design's own decisions.
module mrs_ctrl
  import mrs_pkg::*;
#(
  parameter int TICK = mrs_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Run commands.
  input wire logic run_level_in,
  input wire logic keypad_run_key_in,
  input wire logic keypad_stop_key_in,
  // Terminals.
  input wire logic set_select_in,
  input wire logic third_bank_select_in,
  input wire logic ramp_bypass_in,
  // Frequency and voltage sources.
  input wire logic [15:0] freq_command_in,
  input wire logic [15:0] matched_freq_in,
  input wire logic [2:0][19:0] ext_accel_in,
  input wire logic [2:0][19:0] ext_decel_in,
  input wire logic [9:0] supply_volt_in,
  // Drive outputs.
  output logic [15:0] output_freq_out,
  output logic drive_enable_out,
  output logic [9:0] voltage_ref_out,
  output logic regulation_active_out,
  output logic decelerating_out,
  output logic trip_reset_out
);
  import mrs_pkg::*;

  if (TICK < 2 || TICK >= (1 << 20)) begin : g_bad
    $error("mrs_ctrl: tick count out of range");
  end

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] thr;
    logic [9:0] wait_t;
    logic [15:0] fmax;
    logic [2:0][19:0] acc_t;
    logic [2:0][19:0] dec_t;
    logic [2:0][15:0] base;
    mrs_state_e state;
    logic [23:0] acc;
    logic [19:0] tcnt;
    logic [13:0] wcnt;
    logic [23:0] up;
    logic [23:0] dn;
    logic dsel;
    logic dstart;
    logic run_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic trip_rst;
    logic drv;
    logic dec;
    logic reg_act;
    logic [15:0] fout;
    logic [9:0] vref;
  } mrs_ctrl_s;

  mrs_ctrl_s r;
  mrs_ctrl_s next_r;
  mrs_div_if #(.DW(24), .VW(20)) dv();

  mrs_div #(.DW(24), .VW(20)) u_div (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .div(dv.slave)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Word index of a mapped register, or all ones when unmapped.
  function automatic logic [5:0] reg_sel(input logic [7:0] a);
    reg_sel = (a[1:0] == 2'h0 && a <= OFF_VOUT) ? a[7:2] : 6'h3F;
  endfunction

  // Moves the accumulator one step toward the target and never past it.
  function automatic logic [23:0] step_to(input logic [23:0] a, input logic [23:0] t,
                                          input logic [23:0] u, input logic [23:0] d);
    logic [24:0] s;
    s = {1'b0, a} + {1'b0, u};
    if (a < t) begin
      step_to = (s >= {1'b0, t}) ? t : s[23:0];
    end else begin
      step_to = (a - t > d) ? a - d : t;
    end
  endfunction

  logic [1:0] set_idx;
  logic [1:0] rts;
  logic [19:0] accel_t;
  logic [19:0] decel_t;
  logic [15:0] target;
  logic [23:0] tgt_acc;
  logic [15:0] restart_f;
  logic key_src;
  logic start_req;
  logic stop_req;
  logic reset_ok;
  logic tick;
  logic setup;
  logic wr_go;
  logic bad;
  logic [5:0] sel;
  logic [31:0] rd_val;
  logic [23:0] dq;

  // Set selection gives the third set priority when both terminals are on.
  assign set_idx = third_bank_select_in ? 2'd2 : (set_select_in ? 2'd1 : 2'd0);
  assign rts = r.ctrl[F_RTS+:2];
  // External time sources are forced to at least one unit so the divider never sees zero.
  assign accel_t = (rts == RTS_KEYPAD) ? r.acc_t[set_idx] :
                   ((ext_accel_in[2'(rts - 2'd1)] == 20'h0) ? TIME_MIN : ext_accel_in[2'(rts - 2'd1)]);
  assign decel_t = (rts == RTS_KEYPAD) ? r.dec_t[set_idx] :
                   ((ext_decel_in[2'(rts - 2'd1)] == 20'h0) ? TIME_MIN : ext_decel_in[2'(rts - 2'd1)]);
  assign target = (freq_command_in > r.fmax) ? r.fmax : freq_command_in;
  assign tgt_acc = {target, 8'h00};
  assign restart_f = (r.ctrl[F_RAC+:2] == RESTART_MATCH && matched_freq_in >= r.thr) ?
                     matched_freq_in : 16'h0000;

  // Keypad source takes key pulses; others take edges of the run level.
  assign key_src = r.ctrl[F_RCS+:3] == SRC_KEYPAD;
  assign start_req = key_src ? keypad_run_key_in : (run_level_in & ~r.run_prev);
  assign stop_req = key_src ? keypad_stop_key_in :
                    ((~run_level_in & r.run_prev) |
                     (keypad_stop_key_in & r.ctrl[F_SKP+:2] == KEY_ALL));
  assign reset_ok = keypad_stop_key_in & (key_src | r.ctrl[F_SKP+:2] != KEY_NONE);
  assign tick = r.tcnt == 20'(TICK - 1);

  // Steps are in 1/256 of 0.01 Hz per tick; zero would freeze the ramp.
  assign dq = (dv.quotient == 24'h0) ? 24'h000001 : dv.quotient;
  assign dv.start = r.dstart;
  assign dv.dividend = {r.fmax, 8'h00};
  assign dv.divisor = r.dsel ? decel_t : accel_t;

  // ----------------------------------------------------------------
  // APB decode, validation and read data
  // ----------------------------------------------------------------
  assign setup = psel_in & ~penable_in;
  assign wr_go = psel_in & penable_in & r.pready & pwrite_in & ~r.pslverr;
  assign sel = reg_sel(paddr_in);

  // Writes out of range are refused with an error and change nothing.
  always_comb begin
    logic [15:0] c;
    c = pwdata_in[15:0];
    bad = 1'b0;
    rd_val = 32'h0000_0000;
    case (sel)
      OFF_CTRL[7:2]: begin
        rd_val = {16'h0000, r.ctrl};
        bad = pwrite_in & (c[F_SMS+:2] > STOP_COAST || c[F_RAC+:2] > RESTART_MATCH ||
              c[F_SKP+:2] > KEY_RESET || c[F_RCS+:3] == 3'h0 || c[F_RCS+:3] > SRC_LAST ||
              c[F_VRM+:2] > VR_NODEC || c[F_MVL+:3] > MVL_LAST || pwdata_in[31:16] != 16'h0000);
      end
      OFF_THR[7:2]: begin
        rd_val = {16'h0000, r.thr};
        bad = pwrite_in & (pwdata_in > {16'h0000, THR_MAX});
      end
      OFF_WAIT[7:2]: begin
        rd_val = {22'h000000, r.wait_t};
        bad = pwrite_in & (pwdata_in < {22'h0, WAIT_MIN} || pwdata_in > {22'h0, WAIT_MAX});
      end
      OFF_FMAX[7:2]: begin
        rd_val = {16'h0000, r.fmax};
        bad = pwrite_in & (pwdata_in < {16'h0, FREQ_MIN} || pwdata_in > {16'h0, FREQ_MAX});
      end
      OFF_STAT[7:2]: begin
        rd_val = {27'h0000000, r.dec, r.drv, 3'(r.state)};
        bad = pwrite_in;
      end
      OFF_FOUT[7:2]: begin
        rd_val = {16'h0000, r.fout};
        bad = pwrite_in;
      end
      OFF_VOUT[7:2]: begin
        rd_val = {21'h000000, r.reg_act, r.vref};
        bad = pwrite_in;
      end
      default: begin
        bad = 1'b1;
        for (int i = 0; i < 3; i++) begin
          if (sel == 6'(OFF_ACC0[7:2] + 6'(i)) || sel == 6'(OFF_DEC0[7:2] + 6'(i))) begin
            rd_val = {12'h000, (sel < OFF_DEC0[7:2]) ? r.acc_t[i] : r.dec_t[i]};
            bad = pwrite_in & (pwdata_in < {12'h0, TIME_MIN} || pwdata_in > {12'h0, TIME_MAX});
          end
          if (sel == 6'(OFF_BASE0[7:2] + 6'(i))) begin
            rd_val = {16'h0000, r.base[i]};
            bad = pwrite_in & (pwdata_in < {16'h0, FREQ_MIN} || pwdata_in > {16'h0, r.fmax});
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.dstart = 1'b0;
    next_r.pready = setup;
    next_r.pslverr = setup & bad;
    next_r.trip_rst = reset_ok;
    next_r.run_prev = run_level_in;
    next_r.tcnt = tick ? 20'h0 : r.tcnt + 20'h1;
    if (setup) begin
      next_r.prdata = rd_val;
    end
    // The divider alternates between the accel and decel step.
    if (dv.done) begin
      if (r.dsel) begin
        next_r.dn = dq;
      end else begin
        next_r.up = dq;
      end
      next_r.dsel = ~r.dsel;
    end else if (!dv.busy && !r.dstart) begin
      next_r.dstart = 1'b1;
    end
    if (wr_go) begin
      case (sel)
        OFF_CTRL[7:2]: next_r.ctrl = pwdata_in[15:0];
        OFF_THR[7:2]: next_r.thr = pwdata_in[15:0];
        OFF_WAIT[7:2]: next_r.wait_t = pwdata_in[9:0];
        OFF_FMAX[7:2]: next_r.fmax = pwdata_in[15:0];
        default: begin
          for (int i = 0; i < 3; i++) begin
            if (sel == 6'(OFF_ACC0[7:2] + 6'(i))) next_r.acc_t[i] = pwdata_in[19:0];
            if (sel == 6'(OFF_DEC0[7:2] + 6'(i))) next_r.dec_t[i] = pwdata_in[19:0];
            if (sel == 6'(OFF_BASE0[7:2] + 6'(i))) next_r.base[i] = pwdata_in[15:0];
          end
        end
      endcase
    end
    case (r.state)
      ST_STOP: begin
        next_r.acc = 24'h0;
        if (start_req) next_r.state = ST_RUN;
      end
      ST_RUN: begin
        if (stop_req) begin
          if (r.ctrl[F_SMS+:2] == STOP_COAST) begin
            next_r.state = ST_COAST;
            next_r.acc = 24'h0;
          end else begin
            next_r.state = ST_DECEL;
          end
        end else if (ramp_bypass_in) begin
          next_r.acc = tgt_acc;
        end else if (tick) begin
          next_r.acc = step_to(r.acc, tgt_acc, r.up, r.dn);
        end
      end
      ST_DECEL: begin
        if (start_req) begin
          next_r.state = ST_RUN;
        end else if (r.acc == 24'h0) begin
          next_r.state = ST_STOP;
        end else if (ramp_bypass_in) begin
          next_r.acc = 24'h0;
        end else if (tick) begin
          next_r.acc = step_to(r.acc, 24'h0, r.up, r.dn);
        end
      end
      ST_COAST: begin
        if (start_req) begin
          next_r.state = ST_WAIT;
          next_r.wcnt = 14'(r.wait_t * WAIT_TICKS);
        end
      end
      ST_WAIT: begin
        if (stop_req) begin
          next_r.state = ST_COAST;
        end else if (tick) begin
          if (r.wcnt == 14'h0) begin
            next_r.state = ST_RUN;
            next_r.acc = {restart_f, 8'h00};
          end else begin
            next_r.wcnt = r.wcnt - 14'h1;
          end
        end
      end
      default: begin
        next_r.state = ST_STOP;
        next_r.acc = 24'h0;
      end
    endcase
    next_r.fout = next_r.acc[23:8];
    next_r.drv = next_r.state == ST_RUN || next_r.state == ST_DECEL;
    next_r.dec = next_r.state == ST_DECEL || (next_r.state == ST_RUN && next_r.acc > tgt_acc);
    // Regulation off during deceleration shortens it by burning energy in the motor.
    next_r.reg_act = r.ctrl[F_VRM+:2] == VR_ON ||
                     (r.ctrl[F_VRM+:2] == VR_NODEC && !next_r.dec);
    next_r.vref = next_r.reg_act ? mrs_volt(r.ctrl[F_MVL+:3]) : supply_volt_in;
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '0;
      r.ctrl <= RST_CTRL;
      r.wait_t <= RST_WAIT;
      r.fmax <= RST_FREQ;
      r.acc_t <= {3{RST_TIME}};
      r.dec_t <= {3{RST_TIME}};
      r.base <= {3{RST_FREQ}};
      r.state <= ST_STOP;
    end else begin
      r <= next_r;
    end
  end

  assign prdata_out = r.prdata;
  assign pready_out = r.pready;
  assign pslverr_out = r.pslverr;
  assign output_freq_out = r.fout;
  assign drive_enable_out = r.drv;
  assign voltage_ref_out = r.vref;
  assign regulation_active_out = r.reg_act;
  assign decelerating_out = r.dec;
  assign trip_reset_out = r.trip_rst;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_run_stop;
    r.state == ST_RUN && stop_req;
  endsequence
  sequence s_wait_end;
    r.state == ST_WAIT && !stop_req && tick && r.wcnt == 14'h0;
  endsequence

  a_stop_coast: assert property (
    s_run_stop and r.ctrl[F_SMS+:2] == STOP_COAST |=> r.state == ST_COAST && output_freq_out == 0
    && !drive_enable_out) else $error("coast stop did not remove output");
  a_stop_ramp: assert property (
    s_run_stop and r.ctrl[F_SMS+:2] != STOP_COAST |=> r.state == ST_DECEL && drive_enable_out)
    else $error("ramped stop did not enter deceleration");
  a_decel_zero: assert property (
    r.state == ST_DECEL && !start_req && r.acc == 0 |=> r.state == ST_STOP)
    else $error("stopped state not entered at zero");
  a_restart_freq: assert property (
    s_wait_end |=> r.state == ST_RUN && output_freq_out == (($past(r.ctrl[F_RAC+:2]) ==
    RESTART_MATCH && $past(matched_freq_in) >= $past(r.thr)) ? $past(matched_freq_in) : 0))
    else $error("wrong restart frequency");
  a_wait_hold: assert property (
    r.state == ST_WAIT && r.wcnt != 0 && !stop_req |=> r.state == ST_WAIT)
    else $error("restart before wait time");
  a_key_locked: assert property (
    keypad_stop_key_in && !key_src && r.ctrl[F_SKP+:2] == KEY_NONE |=> !trip_reset_out)
    else $error("trip reset from disabled stop key");
  a_key_keypad: assert property (
    keypad_stop_key_in && key_src |=> trip_reset_out) else $error("keypad stop key ignored");
  a_ramp_bypass: assert property (
    r.state == ST_RUN && !stop_req && ramp_bypass_in |=> output_freq_out == $past(target))
    else $error("bypass did not follow command");
  a_ramp_rise: assert property (
    r.state == ST_RUN && !stop_req && !ramp_bypass_in && tick && r.acc < tgt_acc
    |=> r.acc > $past(r.acc) && r.acc <= $past(tgt_acc)) else $error("ramp did not step up");
  a_reg_off: assert property (
    r.ctrl[F_VRM+:2] == KEY_NONE ##1 r.ctrl[F_VRM+:2] == KEY_NONE |-> !regulation_active_out)
    else $error("regulation active while off");
  a_base_reject: assert property (
    setup && pwrite_in && sel == OFF_BASE0[7:2] && pwdata_in < {16'h0, FREQ_MIN}
    |=> pslverr_out ##1 r.base[0] == $past(r.base[0], 2)) else $error("bad base accepted");
endmodule

// >>> sim/mrs_far_model.sv
/*
  Far side: shaft speed sensing and a rippling mains supply.
  Assumes the bench drives keys and terminals itself.
*/
module mrs_far_model (
  // Drive side.
  input wire logic clk_in,
  input wire logic [15:0] output_freq_in,
  // Sensed values.
  output logic [15:0] matched_freq_out,
  output logic [9:0] supply_volt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    matched_freq_out = 16'h0000;
    supply_volt_out = 10'h1A0;
  end
  // The shaft keeps its last speed while coasting; ripple tests regulation.
  always @(posedge clk_in) begin
    if (output_freq_in != 16'h0000) begin
      matched_freq_out <= output_freq_in;
    end
    supply_volt_out <= supply_volt_out ^ 10'h011;
  end
endmodule

// >>> sim/motor_ramp_stop_control_test.sv
/*
  Self-checking bench of the motor ramp and stop controller.
  Assumes a 20-cycle tick in place of the long default; the APB master waits for pready.
*/
module motor_ramp_stop_control_test;
  import mrs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 20;
  logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, pready, perr;
  logic run = 0, kr = 0, ks = 0, s2 = 0, s3 = 0, byp = 0, de, ra, dec, trip;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] cmd = 16'h0BB8, mf, fo;
  logic [9:0] sv, vref;
  logic [2:0][19:0] ext = {20'h00001, 20'h00001, 20'h00014};
  int err_count = 0, samples_checked = 0;
  mrs_ctrl #(.TICK(TK)) u_mrs_ctrl (.clk_in(clk), .srst_in(srst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .run_level_in(run),
    .keypad_run_key_in(kr), .keypad_stop_key_in(ks), .set_select_in(s2),
    .third_bank_select_in(s3), .ramp_bypass_in(byp), .freq_command_in(cmd),
    .matched_freq_in(mf), .ext_accel_in(ext), .ext_decel_in(ext), .supply_volt_in(sv),
    .output_freq_out(fo), .drive_enable_out(de), .voltage_ref_out(vref),
    .regulation_active_out(ra), .decelerating_out(dec), .trip_reset_out(trip));
  mrs_far_model u_mrs_far_model (.clk_in(clk), .output_freq_in(fo),
    .matched_freq_out(mf), .supply_volt_out(sv));
  always #5 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, then an idle cycle so no strobe is set twice at one edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    chk("pslverr", {31'h0, e}, {31'h0, perr});
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_f(input logic eq, input logic [15:0] v, input int lim);
    int n;
    n = 0;
    while ((fo === v) !== eq && n < lim) begin
      n++;
      @(posedge clk);
    end
  endtask
  // The step divider needs a few of its passes to pick up new times before the run starts.
  task automatic ramp(input logic [15:0] up, dn, input logic ra_dec);
    repeat (120) @(posedge clk);
    run <= 1'b1;
    wait_f(1'b0, 16'h0000, 400);
    chk("first step", up, fo);
    wait_f(1'b1, 16'h0BB8, 400);
    chk("target", 16'h0BB8, fo);
    chk("reg in run", 1, ra);
    run <= 1'b0;
    wait_f(1'b0, 16'h0BB8, 400);
    chk("decel flag", 1, dec);
    chk("reg in decel", ra_dec, ra);
    chk("decel step", 16'h0BB8 - dn, fo);
    wait_f(1'b1, 16'h0000, 400);
    @(posedge clk);
    chk("stopped", 0, de);
  endtask
  task automatic key(input logic [31:0] ctrl, input logic t, d);
    apb(1, OFF_CTRL, ctrl, 0);
    ks <= 1'b1;
    @(posedge clk);
    ks <= 1'b0;
    @(posedge clk);
    chk("trip", t, trip);
    repeat (2) @(posedge clk);
    chk("drive", d, de);
  endtask
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    int n;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(0, OFF_CTRL, 0, 0);
    chk("ctrl reset", 32'h40, rd);
    apb(0, OFF_WAIT, 0, 0);
    chk("wait reset", 32'h0A, rd);
    apb(0, 8'h40, 0, 1);
    apb(1, OFF_BASE0, 32'h0BB7, 1);
    apb(1, OFF_BASE0 + 8'h04, 32'h1771, 1);
    apb(1, OFF_FOUT, 0, 1);
    apb(1, OFF_CTRL, 32'hA040, 0);
    repeat (3) @(posedge clk);
    chk("vref", 10'h1E0, vref);
    chk("reg on", 1, ra);
    apb(1, OFF_CTRL, 32'h0840, 0);
    @(posedge clk);
    chk("reg off", 0, ra);
    apb(1, OFF_CTRL, 32'h40, 0);
    $display("Registers done");
    apb(1, OFF_ACC0, 10, 0);
    apb(1, OFF_DEC0, 20, 0);
    ramp(16'd600, 16'd300, 1'b1);
    apb(1, OFF_ACC0 + 8'h08, 5, 0);
    apb(1, OFF_DEC0 + 8'h08, 5, 0);
    s3 <= 1'b1;
    ramp(16'd1200, 16'd1200, 1'b1);
    s3 <= 1'b0;
    apb(1, OFF_CTRL, 32'h1240, 0);
    ramp(16'd300, 16'd300, 1'b0);
    $display("Ramps done");
    apb(1, OFF_CTRL, 32'h50, 0);
    byp <= 1'b1;
    run <= 1'b1;
    wait_f(1'b1, 16'h0BB8, 4);
    chk("bypass", 16'h0BB8, fo);
    key(32'h50, 0, 1);
    key(32'h60, 1, 1);
    key(32'h40, 1, 0);
    run <= 1'b0;
    apb(1, OFF_CTRL, 32'h90, 0);
    kr <= 1'b1;
    @(posedge clk);
    kr <= 1'b0;
    wait_f(1'b1, 16'h0BB8, 8);
    key(32'h90, 1, 0);
    byp <= 1'b0;
    $display("Keys done");
    apb(1, OFF_WAIT, 3, 0);
    apb(1, OFF_CTRL, 32'h45, 0);
    for (int i = 0; i < 2; i++) begin
      run <= 1'b1;
      wait_f(1'b1, 16'h0BB8, 400);
      run <= 1'b0;
      repeat (2) @(posedge clk);
      chk("coast", 0, {de, fo});
      run <= 1'b1;
      n = 0;
      while (de !== 1'b1 && n < 2000) begin
        n++;
        @(posedge clk);
      end
      chk("retry wait", 1, n >= 30 * TK);
      chk("restart", i == 0 ? 16'h0BB8 : 16'h0000, fo);
      apb(1, OFF_THR, 32'h0FA0, 0);
    end
    $display("Coast done");
    close_out();
  end
  initial begin
    #300_000;
    err_count++;
    close_out();
  end
endmodule
